// [rtl/ssel_defines.svh]
`ifndef SSEL_DEFINES_SVH
`define SSEL_DEFINES_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SSEL_ADDR_W        12
`define SSEL_OFF_INPUT_SEL 12'h040
`define SSEL_OFF_STEP_CTL  12'h044
`define SSEL_OFF_STATUS    12'h048

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define SSEL_STEPS         8
`define SSEL_SEL_W         3
`define SSEL_FIELD_STRIDE  4
`define SSEL_SEL_RESET     32'h0000_0000
`define SSEL_SEL_WMASK     32'h7777_7777
`define SSEL_CTL_RESET     16'h0000
`define SSEL_CTL_END_LSB   0
`define SSEL_CTL_TS_LSB    8
`define SSEL_STAT_BUSY_BIT 0
`define SSEL_STAT_STEP_LSB 4
`define SSEL_LAST_STEP     3'h7

`endif

// [rtl/ssel_pkg.sv]
`default_nettype none

package ssel_pkg;

    typedef logic [11:0] ssel_addr_t;
    typedef logic [31:0] ssel_word_t;
    typedef logic [2:0]  ssel_sel_t;
    typedef logic [2:0]  ssel_step_t;
    typedef logic [7:0]  ssel_flags_t;

    typedef enum logic [1:0] {
        SSEL_IDLE,
        SSEL_REQ,
        SSEL_WAIT
    } ssel_state_e;

endpackage : ssel_pkg

`default_nettype wire

// [rtl/ssel_step_if.sv]
`default_nettype none

interface ssel_step_if;
    import ssel_pkg::*;

    ssel_word_t  sel_word;
    ssel_flags_t end_flags;
    ssel_flags_t ts_flags;
    ssel_step_t  step;
    ssel_sel_t   ain_sel;
    logic        ts_pick;
    logic        is_end;

    modport seq (
        output sel_word,
        output end_flags,
        output ts_flags,
        output step,
        input  ain_sel,
        input  ts_pick,
        input  is_end
    );

    modport mux (
        input  sel_word,
        input  end_flags,
        input  ts_flags,
        input  step,
        output ain_sel,
        output ts_pick,
        output is_end
    );

endinterface : ssel_step_if

`default_nettype wire

// [rtl/ssel_step_mux.sv]
`include "ssel_defines.svh"
`default_nettype none

module ssel_step_mux (
    // step lookup
    ssel_step_if.mux lk
);
    import ssel_pkg::*;

    ssel_sel_t field [`SSEL_STEPS];

    // ------------------------------------------------------------------
    // per-step selector fields, one nibble each, top bit left reserved
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SSEL_STEPS; g++) begin : g_field
            assign field[g] = lk.sel_word[g*`SSEL_FIELD_STRIDE +: `SSEL_SEL_W];
        end
    endgenerate

    // the selector binary value goes to the analog mux unchanged
    assign lk.ain_sel = field[lk.step];
    assign lk.ts_pick = lk.ts_flags[lk.step];
    assign lk.is_end  = lk.end_flags[lk.step];

endmodule : ssel_step_mux

`default_nettype wire

// [rtl/ssel_top.sv]
// Operation
// - Step one converts the input chosen by bits 2:0, a read/write field that resets to zero.
// - Step two converts the input chosen by the read/write field at bits 6:4.
// - Step three converts the input chosen by the read/write field at bits 10:8.
// - Step four converts the input chosen by the read/write field at bits 14:12.
// - Step five converts the input chosen by the read/write field at bits 18:16.
// - Each step drives the analog input mux with its selector's binary value.
// - Bits 31, 27, 23, 19, 15, 11, 7 and 3 read as zero and ignore writes.
// - The input select register holds selectors for eight sample steps.
// - No step after the one flagged as end of sequence is requested for conversion.
// - A step with its temperature pick set samples the internal sensor, not its pin.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`include "ssel_defines.svh"
`default_nettype none

module ssel_top (
    // clock and reset
    input  wire logic               CLK_I,
    input  wire logic               SRST_I,
    // register port
    input  wire ssel_pkg::ssel_addr_t ADDR_I,
    input  wire ssel_pkg::ssel_word_t WDATA_I,
    input  wire logic               WR_I,
    input  wire logic               RD_I,
    output var  ssel_pkg::ssel_word_t RDATA_O,
    // sequence control
    input  wire logic               SEQ_START_I,
    input  wire logic               CONV_DONE_I,
    output var  logic               CONV_REQ_O,
    output var  ssel_pkg::ssel_sel_t AIN_SEL_O,
    output var  logic               TEMP_SEL_O,
    output var  ssel_pkg::ssel_step_t STEP_O,
    output var  logic               BUSY_O,
    output var  logic               SEQ_DONE_O
);
    import ssel_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    ssel_word_t  sel_q;
    ssel_word_t  sel_d;
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    ssel_word_t  rdata_q;
    ssel_word_t  rdata_d;
    ssel_state_e state_q;
    ssel_state_e state_d;
    ssel_step_t  step_q;
    ssel_step_t  step_d;
    logic        req_q;
    ssel_sel_t   ain_q;
    logic        ts_q;
    logic        done_q;
    logic        busy_q;

    ssel_step_if lk ();

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    wire logic       hit_sel  = (ADDR_I == `SSEL_OFF_INPUT_SEL);
    wire logic       hit_ctl  = (ADDR_I == `SSEL_OFF_STEP_CTL);
    wire logic       hit_stat = (ADDR_I == `SSEL_OFF_STATUS);
    wire logic       wr_sel   = WR_I && hit_sel;
    wire logic       wr_ctl   = WR_I && hit_ctl;
    // taken from the next state so the registered pin tracks the state flops
    wire logic       busy_d   = (state_d != SSEL_IDLE);

    // ------------------------------------------------------------------
    // register write
    // ------------------------------------------------------------------
    // reserved bits are never stored, so they read back zero
    wire ssel_word_t sel_wval = WDATA_I & `SSEL_SEL_WMASK;

    assign sel_d   = wr_sel ? sel_wval : sel_q;
    // the upper half of the control word has no storage and reads zero
    assign ctl_d   = wr_ctl ? WDATA_I[15:0] : ctl_q;

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    wire ssel_word_t stat_val = {24'h00_0000, 1'b0, step_q, 3'h0, busy_q};
    wire ssel_word_t rd_mux   = hit_sel  ? sel_q :
                                hit_ctl  ? {16'h0000, ctl_q} :
                                hit_stat ? stat_val : 32'h0000_0000;

    // read data stand for exactly the cycle after the strobe
    assign rdata_d = RD_I ? rd_mux : 32'h0000_0000;

    // ------------------------------------------------------------------
    // step lookup
    // ------------------------------------------------------------------
    assign lk.sel_word  = sel_q;
    assign lk.end_flags = ctl_q[`SSEL_CTL_END_LSB +: `SSEL_STEPS];
    assign lk.ts_flags  = ctl_q[`SSEL_CTL_TS_LSB +: `SSEL_STEPS];
    assign lk.step      = step_q;

    ssel_step_mux u_mux (
        .lk (lk.mux)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // a sequence with no end flag stops after the eighth step rather
    // than wrapping, so a forgotten flag cannot run forever
    wire logic last_step = lk.is_end || (step_q == `SSEL_LAST_STEP);
    wire logic step_over = (state_q == SSEL_WAIT) && CONV_DONE_I;
    wire logic seq_end   = step_over && last_step;
    wire logic enter_req = (state_q == SSEL_REQ);

    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        case (state_q)
            SSEL_IDLE: begin
                if (SEQ_START_I) begin
                    state_d = SSEL_REQ;
                    step_d  = 3'h0;
                end
            end
            SSEL_REQ: begin
                // one cycle to look up the selection, latched on the same edge that the request rises
                state_d = SSEL_WAIT;
            end
            SSEL_WAIT: begin
                if (seq_end) begin
                    state_d = SSEL_IDLE;
                end else if (step_over) begin
                    state_d = SSEL_REQ;
                    step_d  = step_q + 3'h1;
                end
            end
            default: begin
                state_d = SSEL_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // flops
    // ------------------------------------------------------------------
    // reserved bits stay low through the write mask, not through reset alone
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sel_q <= `SSEL_SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ctl_q <= `SSEL_CTL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_q <= SSEL_IDLE;
            step_q  <= 3'h0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
        end
    end

    // busy and done are registered so the pins carry no decode glitches
    // and line up with the state flops
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            done_q <= seq_end;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            req_q <= 1'b0;
        end else begin
            req_q <= enter_req;
        end
    end

    // selection is latched with the request so a later register write
    // cannot disturb a conversion already under way
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ain_q <= 3'h0;
            ts_q  <= 1'b0;
        end else if (enter_req) begin
            ain_q <= lk.ain_sel;
            ts_q  <= lk.ts_pick;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RDATA_O    = rdata_q;
    assign CONV_REQ_O = req_q;
    assign AIN_SEL_O  = ain_q;
    assign TEMP_SEL_O = ts_q;
    assign STEP_O     = step_q;
    assign BUSY_O     = busy_q;
    assign SEQ_DONE_O = done_q;

endmodule : ssel_top

`default_nettype wire

// [verif/ssel_top_props.sv]
`default_nettype none

module ssel_top_props
    import ssel_pkg::*;
(
    // watched ports
    input wire logic       CLK_I, SRST_I, WR_I, RD_I, SEQ_START_I, CONV_DONE_I,
    input wire logic       CONV_REQ_O, TEMP_SEL_O, BUSY_O, SEQ_DONE_O,
    input wire ssel_addr_t ADDR_I,
    input wire ssel_word_t WDATA_I, RDATA_O,
    input wire ssel_sel_t  AIN_SEL_O,
    input wire ssel_step_t STEP_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // shadow of the select word and of the converter wait
    // ------------------------------------------------------------------
    ssel_word_t sel_q;
    logic       wait_q;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sel_q  <= 32'h0;
            wait_q <= 1'b0;
        end else begin
            if (WR_I && ADDR_I == 12'h040) sel_q <= WDATA_I;
            wait_q <= (wait_q || CONV_REQ_O) && !CONV_DONE_I;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    sequence s_start; SEQ_START_I && !BUSY_O; endsequence
    sequence s_step_done; (wait_q || CONV_REQ_O) && CONV_DONE_I; endsequence
    property p_rsvd_zero; RD_I && ADDR_I == 12'h040 |=> (RDATA_O & 32'h8888_8888) == 32'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read high");
    property p_rd_idle; !RD_I |=> RDATA_O == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_first_req; s_start |-> !CONV_REQ_O ##1 (BUSY_O && STEP_O == 3'h0) ##1 CONV_REQ_O;
    endproperty
    a_first_req: assert property (p_first_req) else $error("first step request late");
    // selection is latched at request time, so the bench never writes while busy
    property p_req_sel; CONV_REQ_O |-> BUSY_O && AIN_SEL_O == sel_q[{STEP_O, 2'b00} +: 3];
    endproperty
    a_req_sel: assert property (p_req_sel) else $error("wrong input for step");
    property p_req_pulse; CONV_REQ_O |=> !CONV_REQ_O; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request too long");
    property p_sel_hold;
        !CONV_REQ_O |-> $stable(AIN_SEL_O) && $stable(TEMP_SEL_O);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("selection moved");
    property p_next_step;
        s_step_done |=> (SEQ_DONE_O && !BUSY_O)
                        or (STEP_O == $past(STEP_O) + 3'h1 ##1 CONV_REQ_O);
    endproperty
    a_next_step: assert property (p_next_step) else $error("step did not advance");
    property p_end_quiet; SEQ_DONE_O |=> !SEQ_DONE_O && !CONV_REQ_O; endproperty
    a_end_quiet: assert property (p_end_quiet) else $error("request after sequence end");
endmodule : ssel_top_props

`default_nettype wire

// [verif/test_adc_sequence_input_selector.sv]
`default_nettype none

module test_adc_sequence_input_selector;
    timeunit 1ns;
    timeprecision 1ps;
    import ssel_pkg::*;
    logic       CLK_I = 1'b0, SRST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
    logic       SEQ_START_I = 1'b0, CONV_DONE_I = 1'b0;
    logic       CONV_REQ_O, TEMP_SEL_O, BUSY_O, SEQ_DONE_O;
    ssel_addr_t ADDR_I = 12'h0;
    ssel_word_t WDATA_I = 32'h0, RDATA_O;
    ssel_sel_t  AIN_SEL_O;
    ssel_step_t STEP_O;
    ssel_word_t rq[$], cq[$];
    int         bad_count = 0, cmp_count = 0, cyc = 0;
    logic       rd_d1 = 1'b0, pend = 1'b0, fire;

    ssel_top dut (
        .CLK_I       (CLK_I),
        .SRST_I      (SRST_I),
        .ADDR_I      (ADDR_I),
        .WDATA_I     (WDATA_I),
        .WR_I        (WR_I),
        .RD_I        (RD_I),
        .RDATA_O     (RDATA_O),
        .SEQ_START_I (SEQ_START_I),
        .CONV_DONE_I (CONV_DONE_I),
        .CONV_REQ_O  (CONV_REQ_O),
        .AIN_SEL_O   (AIN_SEL_O),
        .TEMP_SEL_O  (TEMP_SEL_O),
        .STEP_O      (STEP_O),
        .BUSY_O      (BUSY_O),
        .SEQ_DONE_O  (SEQ_DONE_O)
    );
    always #2 CLK_I = ~CLK_I;

    task automatic chk(input ssel_word_t got, input ssel_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // one strobe per call; expected read data rides in d
    task automatic bus(input logic w, input ssel_addr_t a, input ssel_word_t d);
        WR_I <= w;
        RD_I <= !w;
        ADDR_I <= a;
        WDATA_I <= d;
        if (!w) rq.push_back(d);
        @(posedge CLK_I);
    endtask : bus
    task automatic idle();
        WR_I <= 1'b0;
        RD_I <= 1'b0;
        @(posedge CLK_I);
    endtask : idle
    task automatic pulse(input int n);
        repeat (n) begin
            SEQ_START_I <= 1'b1;
            WR_I <= 1'b0;
            RD_I <= 1'b0;
            @(posedge CLK_I);
            SEQ_START_I <= 1'b0;
            @(posedge CLK_I);
        end
    endtask : pulse

    // ------------------------------------------------------------------
    // output watcher and converter stand-in with random latency
    // ------------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (rd_d1) chk(RDATA_O, rq.pop_front());
        rd_d1 <= RD_I;
        if (CONV_REQ_O === 1'b1) begin
            chk(ssel_word_t'({TEMP_SEL_O, STEP_O, AIN_SEL_O}), cq.pop_front());
            pend = 1'b1;
        end
        fire = pend && ($urandom_range(2) == 0);
        if (fire) pend = 1'b0;
        CONV_DONE_I <= fire;
    end
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        ssel_word_t w, f, rd_v;
        int         e;
        void'($urandom(32'h2d9afec7));
        repeat (6) @(posedge CLK_I);
        SRST_I <= 1'b0;
        bus(1'b0, 12'h040, 32'h0);
        bus(1'b1, 12'h040, 32'hffff_ffff);
        bus(1'b0, 12'h040, 32'h7777_7777);
        idle();
        // software update by read-modify-write, reserved bits kept as read
        rd_v = RDATA_O;
        bus(1'b1, 12'h040, rd_v & 32'hffff_ff0f);
        bus(1'b0, 12'h040, 32'h7777_7707);
        bus(1'b0, 12'h100, 32'h0);
        for (int i = 0; i < 10; i++) begin
            w = $urandom();
            f = (i == 0) ? 32'h0 : $urandom();
            bus(1'b1, 12'h040, w);
            bus(1'b1, 12'h044, f);
            bus(1'b0, 12'h040, w & 32'h7777_7777);
            bus(1'b0, 12'h044, {16'h0000, f[15:0]});
            e = 7;
            for (int s = 7; s >= 0; s--) if (f[s]) e = s;
            for (int s = 0; s <= e; s++) cq.push_back({25'h0, f[8+s], s[2:0], w[4*s+:3]});
            // the second start lands while busy and must be ignored
            pulse(2);
            repeat (200) begin
                @(posedge CLK_I);
                if (SEQ_DONE_O === 1'b1) break;
            end
            @(posedge CLK_I);
            chk(ssel_word_t'(cq.size()), 32'h0);
            bus(1'b0, 12'h048, {25'h0, e[2:0], 4'h0});
        end
        // a reset in mid-run must clear what software wrote
        bus(1'b1, 12'h040, 32'h7777_7777);
        bus(1'b1, 12'h044, 32'h0000_ffff);
        SRST_I <= 1'b1;
        idle();
        idle();
        SRST_I <= 1'b0;
        bus(1'b0, 12'h040, 32'h0);
        bus(1'b0, 12'h044, 32'h0);
        idle();
        idle();
        final_report();
    end
endmodule : test_adc_sequence_input_selector

bind ssel_top ssel_top_props u_props (
    .CLK_I       (CLK_I),
    .SRST_I      (SRST_I),
    .WR_I        (WR_I),
    .RD_I        (RD_I),
    .SEQ_START_I (SEQ_START_I),
    .CONV_DONE_I (CONV_DONE_I),
    .CONV_REQ_O  (CONV_REQ_O),
    .TEMP_SEL_O  (TEMP_SEL_O),
    .BUSY_O      (BUSY_O),
    .SEQ_DONE_O  (SEQ_DONE_O),
    .ADDR_I      (ADDR_I),
    .WDATA_I     (WDATA_I),
    .RDATA_O     (RDATA_O),
    .AIN_SEL_O   (AIN_SEL_O),
    .STEP_O      (STEP_O)
);

`default_nettype wire
